// ===== hw/slflc_pkg.sv
// package for the serial loop frame link checker: codes, field layout, register map
// assumes a decoded character stream (8-bit value, k flag, disparity info) from a deserializer
package slflc_pkg;
	// special characters, k-flag set
	localparam logic [7:0] SLFLC_K_FILLER = 8'hFD;
	localparam logic [7:0] SLFLC_K_DELIM = 8'h7C;
	localparam logic [7:0] SLFLC_K_SYNC = 8'hBC;
	localparam logic [7:0] SLFLC_K_CONFIRM = 8'hF7;
	localparam logic [7:0] SLFLC_K_PACING = 8'hFB;
	localparam logic [7:0] SLFLC_K_CANCEL = 8'hFE;
	localparam logic [7:0] SLFLC_K_INVALID = 8'hFC;
	// control byte layout, minimum frame length, idle delimiter guard
	localparam int SLFLC_KIND_LSB = 2;
	localparam int SLFLC_RSV_LSB = 4;
	localparam int SLFLC_MIN_FRAME = 6;
	localparam int SLFLC_IDLE_GUARD = 10;
	// frame kinds
	localparam logic [1:0] SLFLC_KIND_APP = 2'h0;
	localparam logic [1:0] SLFLC_KIND_RSV = 2'h1;
	localparam logic [1:0] SLFLC_KIND_PRIV = 2'h2;
	localparam logic [1:0] SLFLC_KIND_CTRL = 2'h3;
	// reset kinds
	localparam logic [1:0] SLFLC_RST_NEIGHBOR = 2'h0;
	localparam logic [1:0] SLFLC_RST_FULL = 2'h1;
	localparam logic [1:0] SLFLC_RST_RSV = 2'h2;
	localparam logic [1:0] SLFLC_RST_HARD = 2'h3;
	localparam logic [1:0] SLFLC_ORDER_RESET = 2'h0;
	// recovery causes
	localparam logic [2:0] SLFLC_ERR_NONE = 3'h0;
	localparam logic [2:0] SLFLC_ERR_SYMBOL = 3'h1;
	localparam logic [2:0] SLFLC_ERR_SEQUENCE = 3'h2;
	localparam logic [2:0] SLFLC_ERR_ORDER = 3'h3;
	localparam logic [2:0] SLFLC_ERR_KIND = 3'h4;
	localparam logic [2:0] SLFLC_ERR_CTRL_DATA = 3'h5;
	// register map, byte addresses
	localparam logic [11:0] SLFLC_REG_CTRL = 12'h000;
	localparam logic [11:0] SLFLC_REG_STATUS = 12'h004;
	localparam logic [11:0] SLFLC_REG_COUNT = 12'h008;
	localparam logic [31:0] SLFLC_CTRL_RESET = 32'h00000000;
	localparam int SLFLC_CTRL_STATE_LSB = 0;
	localparam int SLFLC_CTRL_MODE_LSB = 2;
	localparam int SLFLC_CTRL_HARD_SELFTEST = 4;
	localparam int SLFLC_CTRL_PRIV_ALLOW = 5;

	typedef enum logic [1:0] {
		SLFLC_PORT_DISABLED,
		SLFLC_PORT_ENABLED,
		SLFLC_PORT_READY,
		SLFLC_PORT_CHECK
	} slflc_port_type;

	typedef enum logic [1:0] {
		SLFLC_MODE_OFF,
		SLFLC_MODE_PRIVILEGED,
		SLFLC_MODE_NORMAL
	} slflc_mode_type;

	typedef enum logic [1:0] {
		SLFLC_RX_HUNT,
		SLFLC_RX_IDLE,
		SLFLC_RX_FRAME
	} slflc_rx_phase_type;

	typedef enum logic [1:0] {
		SLFLC_TX_IDLE,
		SLFLC_TX_BODY,
		SLFLC_TX_CLOSE
	} slflc_tx_phase_type;

	// one received character from the decoder
	typedef struct packed {
		logic valid;
		logic is_k;
		logic [7:0] value;
		logic code_bad;
		logic sub_bad;
		logic disp_neg;
		logic disp_bad;
	} slflc_rx_char_type;

	// one transmit character toward the encoder
	typedef struct packed {
		logic valid;
		logic is_k;
		logic [7:0] value;
	} slflc_tx_char_type;

	// recovery request toward the recovery logic
	typedef struct packed {
		logic req;
		logic [2:0] code;
	} slflc_recover_type;

	typedef struct packed {
		logic pready;
		logic [31:0] prdata;
		logic pslverr;
		logic [31:0] ctrl;
		logic [4:0] state_bits;
		slflc_rx_phase_type rx_phase;
		logic rx_disp_neg;
		logic [7:0] rx_count;
		logic [1:0] rx_ctrl_kind;
		logic [1:0] rx_ctrl_low;
		logic rx_pend_confirm;
		logic rx_pend_pacing;
		logic rx_pend_cancel;
		logic rx_data_since_delim;
		logic [1:0] rx_order_count;
		logic [3:0] idle_delims;
		slflc_recover_type recover;
		logic frame_ok;
		logic [1:0] frame_kind;
		logic confirm_send;
		logic [2:0] reset_do;
		logic link_report_req;
		logic [1:0] tx_order_count;
		slflc_tx_phase_type tx_phase;
		logic tx_kind_ctrl_hold;
		logic tx_ready;
		slflc_tx_char_type tx_out;
		logic [31:0] err_count;
	} slflc_state_type;
endpackage

// ===== hw/slflc_link.sv
// serial loop frame link checker: receive checks, control byte decode, order counters, tx gate
// assumes one clock shared with the 8b/10b decoder and encoder; apb slave for control
`timescale 1ns/1ns
`default_nettype none
module slflc_link
	import slflc_pkg::*;
(
	input wire logic clk,
	input wire logic reset_n,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] pwdata,
	output logic pready,
	output logic [31:0] prdata,
	output logic pslverr,
	input wire slflc_rx_char_type rx_char,
	input wire slflc_tx_char_type tx_in,
	input wire logic tx_frame_start,
	input wire logic tx_frame_end,
	input wire logic tx_cancel,
	output logic tx_ready,
	output slflc_tx_char_type tx_out,
	output slflc_recover_type recover,
	output logic frame_ok,
	output logic [1:0] frame_kind,
	output logic confirm_send,
	output logic [2:0] reset_do,
	output logic link_report_req
);
	slflc_state_type r;
	slflc_state_type next_r;
	slflc_port_type port;
	slflc_mode_type mode;
	logic is_delim, is_filler, is_insert, in_ready, rx_err;
	logic [2:0] err_code;
	logic [1:0] tx_kind;
	logic tx_allowed, tx_is_ctrl_byte;
	logic [3:0] apb_addr_ok;

	assign port = slflc_port_type'(r.ctrl[SLFLC_CTRL_STATE_LSB +: 2]);
	assign mode = slflc_mode_type'(r.ctrl[SLFLC_CTRL_MODE_LSB +: 2]);
	assign in_ready = (port == SLFLC_PORT_READY);
	assign is_delim = rx_char.valid && rx_char.is_k && rx_char.value == SLFLC_K_DELIM;
	assign is_filler = rx_char.valid && rx_char.is_k && rx_char.value == SLFLC_K_FILLER;
	assign is_insert = rx_char.valid && rx_char.is_k && !is_delim && !is_filler
		&& rx_char.value != SLFLC_K_CANCEL && rx_char.value != SLFLC_K_SYNC;
	assign tx_kind = tx_in.value[SLFLC_KIND_LSB +: 2];
	assign apb_addr_ok = {1'b0, paddr == SLFLC_REG_COUNT, paddr == SLFLC_REG_STATUS,
		paddr == SLFLC_REG_CTRL};

	always_comb begin
		tx_is_ctrl_byte = (r.tx_phase == SLFLC_TX_IDLE) && tx_frame_start;
		tx_allowed = 1'b0;
		if (tx_kind == SLFLC_KIND_CTRL) begin
			tx_allowed = (port != SLFLC_PORT_DISABLED) && (mode != SLFLC_MODE_OFF);
		end else if (tx_kind == SLFLC_KIND_APP) begin
			tx_allowed = in_ready && mode == SLFLC_MODE_NORMAL;
		end else begin
			tx_allowed = in_ready && mode != SLFLC_MODE_OFF;
		end
	end

	always_comb begin
		next_r = r;
		rx_err = 1'b0;
		err_code = SLFLC_ERR_NONE;
		next_r.recover = '0;
		next_r.frame_ok = 1'b0;
		next_r.confirm_send = 1'b0;
		next_r.reset_do = 3'h0;
		next_r.link_report_req = 1'b0;
		next_r.pready = 1'b0;
		next_r.pslverr = 1'b0;
		// apb slave, one wait state
		if (psel && penable && !r.pready) begin
			next_r.pready = 1'b1;
			next_r.pslverr = ~|apb_addr_ok;
			next_r.prdata = 32'h00000000;
			if (pwrite && apb_addr_ok[0]) begin
				next_r.ctrl = pwdata;
			end
			if (!pwrite) begin
				case (1'b1)
					apb_addr_ok[0]: next_r.prdata = r.ctrl;
					apb_addr_ok[1]: next_r.prdata = {20'h00000, r.rx_order_count,
						r.tx_order_count, r.rx_disp_neg, r.rx_phase, r.state_bits};
					apb_addr_ok[2]: next_r.prdata = r.err_count;
					default: next_r.prdata = 32'h00000000;
				endcase
			end
		end
		next_r.state_bits = {port == SLFLC_PORT_DISABLED, mode, port};
		// receive path
		if (rx_char.valid && !is_filler) begin
			if (r.rx_phase == SLFLC_RX_HUNT) begin
				if (rx_char.is_k && (rx_char.value == SLFLC_K_DELIM
					|| rx_char.value == SLFLC_K_SYNC)) begin
					next_r.rx_disp_neg = rx_char.disp_neg;
					next_r.rx_phase = SLFLC_RX_IDLE;
					next_r.idle_delims = 4'h0;
				end
			end else begin
				if (rx_char.disp_bad) begin
					next_r.rx_phase = SLFLC_RX_HUNT;
				end else begin
					next_r.rx_disp_neg = rx_char.disp_neg;
				end
				if (in_ready && (rx_char.code_bad || rx_char.sub_bad || rx_char.disp_bad
					|| (rx_char.is_k && rx_char.value == SLFLC_K_INVALID))) begin
					rx_err = 1'b1;
					err_code = SLFLC_ERR_SYMBOL;
					next_r.link_report_req = 1'b1;
				end
				// pairing checks
				if ((r.rx_pend_confirm && !(rx_char.is_k && rx_char.value == SLFLC_K_CONFIRM))
					|| (r.rx_pend_pacing && !(rx_char.is_k && rx_char.value == SLFLC_K_PACING))
					|| (r.rx_pend_cancel && !is_delim)) begin
					if (in_ready && !rx_err) begin
						rx_err = 1'b1;
						err_code = SLFLC_ERR_SEQUENCE;
					end
				end
				next_r.rx_pend_confirm = !r.rx_pend_confirm && rx_char.is_k
					&& rx_char.value == SLFLC_K_CONFIRM;
				next_r.rx_pend_pacing = !r.rx_pend_pacing && rx_char.is_k
					&& rx_char.value == SLFLC_K_PACING;
				next_r.rx_pend_cancel = rx_char.is_k && rx_char.value == SLFLC_K_CANCEL;
				if (next_r.rx_pend_cancel && !r.rx_data_since_delim && in_ready && !rx_err) begin
					rx_err = 1'b1;
					err_code = SLFLC_ERR_SEQUENCE;
				end
				if (is_insert && r.rx_phase == SLFLC_RX_IDLE
					&& r.idle_delims < 4'(SLFLC_IDLE_GUARD)
					&& (in_ready || port == SLFLC_PORT_CHECK) && !rx_err) begin
					rx_err = 1'b1;
					err_code = SLFLC_ERR_SEQUENCE;
				end
				if (!rx_char.is_k) begin
					next_r.rx_data_since_delim = 1'b1;
					next_r.rx_phase = rx_char.disp_bad ? SLFLC_RX_HUNT : SLFLC_RX_FRAME;
					if (r.rx_count != 8'hFF) begin
						next_r.rx_count = r.rx_count + 8'h01;
					end
					if (r.rx_count == 8'h00) begin
						next_r.rx_ctrl_kind = rx_char.value[SLFLC_KIND_LSB +: 2];
						next_r.rx_ctrl_low = rx_char.value[1:0];
					end
				end
				if (is_delim) begin
					next_r.rx_count = 8'h00;
					next_r.rx_data_since_delim = 1'b0;
					next_r.rx_phase = rx_char.disp_bad ? SLFLC_RX_HUNT : SLFLC_RX_IDLE;
					// saturates so a long idle run never re-arms the insert guard
					if (r.rx_phase != SLFLC_RX_IDLE) begin
						next_r.idle_delims = 4'h0;
					end else if (r.idle_delims != 4'hF) begin
						next_r.idle_delims = r.idle_delims + 4'h1;
					end
					if (r.rx_data_since_delim && !r.rx_pend_cancel && !rx_err) begin
						if (r.rx_count < 8'(SLFLC_MIN_FRAME)) begin
						end else if (r.rx_ctrl_kind == SLFLC_KIND_CTRL) begin
							if (r.rx_count > 8'(SLFLC_MIN_FRAME + 1)) begin
								rx_err = 1'b1;
								err_code = SLFLC_ERR_CTRL_DATA;
							end else if (r.rx_ctrl_low == SLFLC_RST_RSV) begin
								rx_err = 1'b1;
								err_code = SLFLC_ERR_KIND;
							end else begin
								next_r.frame_ok = 1'b1;
								next_r.frame_kind = r.rx_ctrl_kind;
								case (r.rx_ctrl_low)
									SLFLC_RST_NEIGHBOR: next_r.reset_do = 3'h1;
									SLFLC_RST_FULL: next_r.reset_do = 3'h2;
									SLFLC_RST_HARD: next_r.reset_do = {1'b1,
										r.ctrl[SLFLC_CTRL_HARD_SELFTEST], 1'b0};
									default: next_r.reset_do = 3'h0;
								endcase
							end
						end else if (r.rx_ctrl_low != r.rx_order_count) begin
							rx_err = 1'b1;
							err_code = SLFLC_ERR_ORDER;
						end else if (r.rx_ctrl_kind == SLFLC_KIND_RSV) begin
							rx_err = 1'b1;
							err_code = SLFLC_ERR_KIND;
						end else begin
							next_r.rx_order_count = r.rx_order_count + 2'h1;
							if (!(r.rx_ctrl_kind == SLFLC_KIND_APP
								&& mode != SLFLC_MODE_NORMAL)) begin
								next_r.frame_ok = 1'b1;
								next_r.frame_kind = r.rx_ctrl_kind;
								next_r.confirm_send = 1'b1;
							end
						end
					end
				end
			end
		end
		if (rx_err) begin
			next_r.recover.req = 1'b1;
			next_r.recover.code = err_code;
			next_r.err_count = r.err_count + 32'h00000001;
		end
		// transmit gate and order stamping
		next_r.tx_out = '0;
		next_r.tx_ready = 1'b1;
		if (tx_in.valid) begin
			next_r.tx_out = tx_in;
			case (r.tx_phase)
				SLFLC_TX_IDLE: begin
					if (tx_is_ctrl_byte && !tx_in.is_k) begin
						if (!tx_allowed) begin
							next_r.tx_out = '0;
							next_r.tx_phase = SLFLC_TX_CLOSE;
						end else begin
							next_r.tx_phase = SLFLC_TX_BODY;
							next_r.tx_kind_ctrl_hold = (tx_kind == SLFLC_KIND_CTRL);
							if (tx_kind != SLFLC_KIND_CTRL) begin
								next_r.tx_out.value = {tx_in.value[7:2], r.tx_order_count};
							end
						end
					end
				end
				SLFLC_TX_BODY: begin
					if (tx_cancel) begin
						next_r.tx_phase = SLFLC_TX_IDLE;
					end else if (tx_frame_end) begin
						next_r.tx_phase = SLFLC_TX_IDLE;
						if (!r.tx_kind_ctrl_hold) begin
							next_r.tx_order_count = r.tx_order_count + 2'h1;
						end
					end
				end
				// refused frame: swallow everything up to its closing delimiter
				SLFLC_TX_CLOSE: begin
					next_r.tx_out = '0;
					if (tx_frame_end) begin
						next_r.tx_phase = SLFLC_TX_IDLE;
					end
				end
				default: next_r.tx_phase = SLFLC_TX_IDLE;
			endcase
		end
		if (port == SLFLC_PORT_DISABLED) begin
			next_r.tx_order_count = SLFLC_ORDER_RESET;
			next_r.rx_order_count = SLFLC_ORDER_RESET;
			if (r.rx_phase != SLFLC_RX_HUNT && next_r.rx_phase == SLFLC_RX_FRAME) begin
				next_r.rx_phase = SLFLC_RX_IDLE;
			end
		end
	end

	always_ff @(posedge clk) begin
		if (!reset_n) begin
			r <= '0;
			r.ctrl <= SLFLC_CTRL_RESET;
			r.tx_ready <= 1'b1;
		end else begin
			r <= next_r;
		end
	end

	assign pready = r.pready;
	assign prdata = r.prdata;
	assign pslverr = r.pslverr;
	assign tx_ready = r.tx_ready;
	assign tx_out = r.tx_out;
	assign recover = r.recover;
	assign frame_ok = r.frame_ok;
	assign frame_kind = r.frame_kind;
	assign confirm_send = r.confirm_send;
	assign reset_do = r.reset_do;
	assign link_report_req = r.link_report_req;

	property p_order_clear;
		@(posedge clk) disable iff (!reset_n)
		(port == SLFLC_PORT_DISABLED) |=> (r.tx_order_count == 2'h0 && r.rx_order_count == 2'h0);
	endproperty
	a_order_clear: assert property (p_order_clear) else $error("order counts not cleared");

	property p_report_on_symbol;
		@(posedge clk) disable iff (!reset_n)
		link_report_req |-> (recover.req && recover.code == SLFLC_ERR_SYMBOL);
	endproperty
	a_report_on_symbol: assert property (p_report_on_symbol)
		else $error("report without error");

	property p_recover_pulse;
		@(posedge clk) disable iff (!reset_n)
		recover.req |-> recover.code != SLFLC_ERR_NONE;
	endproperty
	a_recover_pulse: assert property (p_recover_pulse)
		else $error("recovery without cause");

	property p_no_err_out_ready;
		@(posedge clk) disable iff (!reset_n)
		(!in_ready && $stable(r.ctrl)) |=> !link_report_req;
	endproperty
	a_no_err_out_ready: assert property (p_no_err_out_ready)
		else $error("report outside ready");

	property p_rx_bump;
		@(posedge clk) disable iff (!reset_n)
		(in_ready && $stable(r.ctrl) && r.rx_order_count != $past(r.rx_order_count))
			|-> r.rx_order_count == $past(r.rx_order_count) + 2'h1;
	endproperty
	a_rx_bump: assert property (p_rx_bump) else $error("rx order count jumped");

	property p_reset_only_valid;
		@(posedge clk) disable iff (!reset_n)
		(reset_do != 3'h0) |-> (frame_ok && frame_kind == SLFLC_KIND_CTRL);
	endproperty
	a_reset_only_valid: assert property (p_reset_only_valid)
		else $error("reset on bad frame");

	property p_confirm_not_ctrl;
		@(posedge clk) disable iff (!reset_n)
		confirm_send |-> (frame_ok && frame_kind != SLFLC_KIND_CTRL);
	endproperty
	a_confirm_not_ctrl: assert property (p_confirm_not_ctrl)
		else $error("confirm on control");

	property p_tx_drop;
		@(posedge clk) disable iff (!reset_n)
		(r.tx_phase == SLFLC_TX_CLOSE) |=> !tx_out.valid;
	endproperty
	a_tx_drop: assert property (p_tx_drop) else $error("refused char sent");

	sequence s_tx_stamp;
		tx_in.valid && tx_is_ctrl_byte && !tx_in.is_k && tx_allowed
			&& tx_kind != SLFLC_KIND_CTRL;
	endsequence
	property p_tx_stamp;
		@(posedge clk) disable iff (!reset_n)
		s_tx_stamp |=> tx_out.value[1:0] == $past(r.tx_order_count);
	endproperty
	a_tx_stamp: assert property (p_tx_stamp) else $error("order not stamped");

	property p_tx_ctl_hold;
		@(posedge clk) disable iff (!reset_n)
		(r.tx_phase == SLFLC_TX_BODY && r.tx_kind_ctrl_hold && port != SLFLC_PORT_DISABLED)
			|=> r.tx_order_count == $past(r.tx_order_count);
	endproperty
	a_tx_ctl_hold: assert property (p_tx_ctl_hold) else $error("ctrl frame counted");

	sequence s_apb_access;
		psel && penable && !pready;
	endsequence
	property p_apb_answer;
		@(posedge clk) disable iff (!reset_n)
		s_apb_access |=> pready;
	endproperty
	a_apb_answer: assert property (p_apb_answer) else $error("apb answer missing");
endmodule
`default_nettype wire

// ===== bench/slflc_peer.sv
// adjacent port model: feeds decoded characters into the receiver
// assumes one caller at a time; the line idles on repeated delimiters
`timescale 1ns/1ns
`default_nettype none
module slflc_peer
	import slflc_pkg::*;
(
	input wire logic clk,
	output var slflc_rx_char_type rx_char
);
	initial rx_char = '0;
	// e: bit 0 code, bit 1 sub-block, bit 2 disparity error
	task automatic putx(input logic k, input logic [7:0] v, input logic [2:0] e);
		@(posedge clk);
		rx_char <= '{valid: 1'b1, is_k: k, value: v, code_bad: e[0], sub_bad: e[1],
			disp_neg: 1'($urandom), disp_bad: e[2]};
	endtask
	task automatic put(input logic k, input logic [7:0] v, input logic bad);
		putx(k, v, {2'b00, bad});
	endtask
	// idle delimiters, also the disparity reference
	task automatic idle(input int n);
		repeat (n) put(1'b1, SLFLC_K_DELIM, 1'b0);
	endtask
	task automatic frame(input logic [7:0] ctl, input int len, input logic fill);
		put(1'b0, ctl, 1'b0);
		for (int i = 1; i < len; i++) begin
			if (fill && i == 2) begin
				put(1'b1, SLFLC_K_FILLER, 1'b0);
			end
			put(1'b0, 8'($urandom), 1'b0);
		end
		put(1'b1, SLFLC_K_DELIM, 1'b0);
	endtask
	// data first, so the cancel never follows a delimiter
	task automatic cancel(input int len);
		repeat (len) put(1'b0, 8'($urandom), 1'b0);
		put(1'b1, SLFLC_K_CANCEL, 1'b0);
		put(1'b1, SLFLC_K_DELIM, 1'b0);
	endtask
endmodule
`default_nettype wire

// ===== bench/test_serial_loop_frame_link_checker.sv
// self-checking bench: apb control, receive checks through the peer, transmit stamping
// assumes the peer model drives rx_char; a watcher compares queued notes to outputs
`timescale 1ns/1ns
`default_nettype none
module test_serial_loop_frame_link_checker
	import slflc_pkg::*;
;
	logic clk = 1'b0;
	logic reset_n, psel, penable, pwrite;
	logic [11:0] paddr;
	logic [31:0] pwdata;
	logic pready, pslverr, er, tx_ready, frame_ok, confirm_send, link_report_req;
	logic [31:0] prdata, rd;
	slflc_rx_char_type rx_char;
	slflc_tx_char_type tx_in, tx_out, te, tx_q[$];
	logic tx_frame_start, tx_frame_end, tx_cancel;
	logic tx_seen = 1'b0;
	slflc_recover_type recover;
	logic [1:0] frame_kind, tc, txc_q[$], tcnt = 2'h0;
	logic [2:0] reset_do;
	logic [11:0] w, e, m, ev_q[$], evm_q[$];
	int failures = 0, checks = 0;
	assign w = {frame_ok, confirm_send, reset_do, link_report_req, recover.req, recover.code,
		frame_kind};
	always #2 clk = ~clk;
	slflc_link u_slflc_link (.clk(clk), .reset_n(reset_n), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready), .prdata(prdata),
		.pslverr(pslverr), .rx_char(rx_char), .tx_in(tx_in), .tx_frame_start(tx_frame_start),
		.tx_frame_end(tx_frame_end), .tx_cancel(tx_cancel), .tx_ready(tx_ready),
		.tx_out(tx_out), .recover(recover), .frame_ok(frame_ok), .frame_kind(frame_kind),
		.confirm_send(confirm_send), .reset_do(reset_do), .link_report_req(link_report_req));
	slflc_peer u_slflc_peer (.clk(clk), .rx_char(rx_char));
	task automatic complete_run;
		$display("checks %0d failures %0d", checks, failures);
		if (failures == 0 && checks > 0) begin
			$display("NO MISMATCHES");
		end else begin
			$display("MISMATCHES SEEN");
		end
		$finish;
	endtask
	task automatic check(input string what, input logic [31:0] x, input logic [31:0] g);
		checks++;
		if (g !== x) begin
			failures++;
			$display("BAD %s expected %h seen %h", what, x, g);
		end
	endtask
	function automatic logic [11:0] okv(input logic [1:0] k, input logic a, input logic [2:0] r);
		return {1'b1, a, r, 5'h00, k};
	endfunction
	function automatic logic [11:0] errv(input logic [2:0] c);
		return {7'h01, c, 2'h0};
	endfunction
	function automatic logic [7:0] cb(input logic [1:0] k, input logic [1:0] n);
		return {4'h0, k, n};
	endfunction
	task automatic note(input logic [11:0] ev, input logic [11:0] mk);
		ev_q.push_back(ev);
		evm_q.push_back(mk);
	endtask
	task automatic rxf(input logic [11:0] ev, input logic [11:0] mk, input logic [7:0] ctl,
		input int len);
		if (mk !== 12'h000) begin
			note(ev, mk);
		end
		u_slflc_peer.frame(ctl, len, len == 7);
	endtask
	task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
		@(posedge clk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= wr;
		paddr <= a;
		pwdata <= d;
		@(posedge clk);
		penable <= 1'b1;
		// no limit here: the watchdog ends a hung wait
		do begin
			@(posedge clk);
		end while (pready !== 1'b1);
		rd = prdata;
		er = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	// care 1 compares the whole char, 2 only that it is blanked
	task automatic txp(input logic k, input logic [7:0] v, input logic [2:0] f,
		input logic [1:0] care, input logic [7:0] xv);
		@(posedge clk);
		tx_in <= '{valid: 1'b1, is_k: k, value: v};
		{tx_frame_start, tx_frame_end, tx_cancel} <= f;
		tx_q.push_back('{valid: 1'b1, is_k: k, value: xv});
		txc_q.push_back(care);
	endtask
	task automatic txf(input logic [1:0] kind, input logic ok, input logic cut);
		logic [7:0] c, v;
		logic [1:0] s;
		c = cb(kind, 2'h3);
		// refused frame blanked up to its closing delimiter
		s = ok ? 2'd1 : 2'd2;
		txp(1'b1, SLFLC_K_DELIM, 3'b000, 2'd1, SLFLC_K_DELIM);
		txp(1'b0, c, 3'b100, ok ? 2'd1 : 2'd2,
			kind == SLFLC_KIND_CTRL ? c : {c[7:2], tcnt});
		repeat (5) begin
			v = 8'($urandom);
			txp(1'b0, v, 3'b000, s, v);
		end
		if (cut) begin
			txp(1'b1, SLFLC_K_CANCEL, 3'b001, s, SLFLC_K_CANCEL);
		end
		txp(1'b1, SLFLC_K_DELIM, 3'b010, s, SLFLC_K_DELIM);
		@(posedge clk);
		tx_in <= '0;
		{tx_frame_start, tx_frame_end, tx_cancel} <= 3'b000;
		if (ok && !cut && kind != SLFLC_KIND_CTRL) begin
			tcnt++;
		end
	endtask
	always @(posedge clk) begin
		if (reset_n === 1'b1 && (|w[11:5]) !== 1'b0) begin
			if (ev_q.size() == 0) begin
				check("rx event spare", 32'h0, 32'(w));
			end else begin
				e = ev_q.pop_front();
				m = evm_q.pop_front();
				check("rx event", 32'(e & m), 32'(w & m));
			end
		end
		if (tx_seen) begin
			te = tx_q.pop_front();
			tc = txc_q.pop_front();
			if (tc == 2'd1) check("tx char", 32'(te), 32'(tx_out));
			if (tc == 2'd2) check("tx blank", 32'h0, 32'(tx_out.valid));
		end
		tx_seen <= tx_in.valid;
	end
	initial begin
		reset_n <= 1'b0;
		{psel, penable, pwrite} <= 3'b000;
		paddr <= 12'h000;
		pwdata <= 32'h00000000;
		tx_in <= '0;
		{tx_frame_start, tx_frame_end, tx_cancel} <= 3'b000;
		void'($urandom(32'h1CD1628F));
		repeat (3) @(posedge clk);
		reset_n <= 1'b1;
		u_slflc_peer.idle(4);
		apb(1'b0, SLFLC_REG_CTRL, 32'h0);
		check("ctrl reset", SLFLC_CTRL_RESET, rd);
		apb(1'b0, 12'h00C, 32'h0);
		check("unmapped err", 32'h1, 32'(er));
		check("unmapped data", 32'h0, rd);
		apb(1'b1, SLFLC_REG_CTRL, 32'h0000000A);
		apb(1'b0, SLFLC_REG_CTRL, 32'h0);
		check("ctrl", 32'h0000000A, rd);
		check("tx ready", 32'h1, 32'(tx_ready));
		$display("registers done");
		u_slflc_peer.idle(12);
		rxf(okv(SLFLC_KIND_APP, 1, 0), 12'hFFF, cb(SLFLC_KIND_APP, 0), 6);
		rxf(okv(SLFLC_KIND_APP, 1, 0), 12'hFFF, cb(SLFLC_KIND_APP, 1), 7);
		rxf(okv(SLFLC_KIND_PRIV, 1, 0), 12'hFFF, cb(SLFLC_KIND_PRIV, 2), 8);
		rxf(errv(SLFLC_ERR_KIND), 12'hFFC, cb(SLFLC_KIND_RSV, 3), 6);
		rxf(errv(SLFLC_ERR_ORDER), 12'hFFC, cb(SLFLC_KIND_APP, 0), 6);
		rxf(12'h0, 12'h0, cb(SLFLC_KIND_APP, 3), 5);
		u_slflc_peer.cancel(3);
		rxf(okv(SLFLC_KIND_APP, 1, 0), 12'hFFF, cb(SLFLC_KIND_APP, 3), 6);
		$display("receive frames done");
		for (int r = 0; r < 4; r++) begin
			if (r == 2) note(errv(SLFLC_ERR_KIND), 12'hFFC);
			else note(okv(SLFLC_KIND_CTRL, 0, r == 3 ? 3'h4 : 3'(r + 1)), 12'hFFF);
			u_slflc_peer.frame(cb(SLFLC_KIND_CTRL, 2'(r)), 6, 1'b0);
		end
		apb(1'b1, SLFLC_REG_CTRL, 32'h0000001A);
		rxf(okv(SLFLC_KIND_CTRL, 0, 3'h6), 12'hFFF, cb(SLFLC_KIND_CTRL, 3), 6);
		rxf(errv(SLFLC_ERR_CTRL_DATA), 12'hFFC, cb(SLFLC_KIND_CTRL, 0), 9);
		rxf(okv(SLFLC_KIND_APP, 1, 0), 12'hFFF, cb(SLFLC_KIND_APP, 0), 6);
		$display("control frames done");
		u_slflc_peer.idle(12);
		u_slflc_peer.put(1'b1, SLFLC_K_CONFIRM, 1'b0);
		u_slflc_peer.put(1'b1, SLFLC_K_CONFIRM, 1'b0);
		u_slflc_peer.put(1'b1, SLFLC_K_PACING, 1'b0);
		u_slflc_peer.put(1'b1, SLFLC_K_PACING, 1'b0);
		u_slflc_peer.idle(12);
		note(errv(SLFLC_ERR_SEQUENCE), 12'hFFC);
		u_slflc_peer.put(1'b1, SLFLC_K_CONFIRM, 1'b0);
		u_slflc_peer.idle(12);
		note(errv(SLFLC_ERR_SEQUENCE), 12'hFFC);
		u_slflc_peer.put(1'b1, SLFLC_K_CANCEL, 1'b0);
		u_slflc_peer.idle(12);
		note(12'h040, 12'hFC0);
		u_slflc_peer.put(1'b1, SLFLC_K_INVALID, 1'b1);
		u_slflc_peer.idle(12);
		note(12'h040, 12'hFC0);
		u_slflc_peer.putx(1'b1, SLFLC_K_DELIM, 3'b010);
		u_slflc_peer.idle(12);
		note(12'h040, 12'hFC0);
		u_slflc_peer.putx(1'b1, SLFLC_K_DELIM, 3'b100);
		u_slflc_peer.idle(12);
		rxf(okv(SLFLC_KIND_APP, 1, 0), 12'hFFF, cb(SLFLC_KIND_APP, 1), 6);
		apb(1'b1, SLFLC_REG_CTRL, 32'h0);
		tcnt = 2'h0;
		u_slflc_peer.put(1'b1, SLFLC_K_INVALID, 1'b1);
		u_slflc_peer.idle(12);
		apb(1'b1, SLFLC_REG_CTRL, 32'h0000000A);
		u_slflc_peer.idle(12);
		rxf(okv(SLFLC_KIND_APP, 1, 0), 12'hFFF, cb(SLFLC_KIND_APP, 0), 6);
		$display("sequence and symbol done");
		txf(SLFLC_KIND_APP, 1, 0);
		txf(SLFLC_KIND_APP, 1, 0);
		txf(SLFLC_KIND_CTRL, 1, 0);
		txf(SLFLC_KIND_APP, 1, 1);
		txf(SLFLC_KIND_RSV, 1, 0);
		apb(1'b1, SLFLC_REG_CTRL, 32'h00000006);
		txf(SLFLC_KIND_APP, 0, 0);
		txf(SLFLC_KIND_PRIV, 1, 0);
		apb(1'b1, SLFLC_REG_CTRL, 32'h00000009);
		txf(SLFLC_KIND_CTRL, 1, 0);
		txf(SLFLC_KIND_PRIV, 0, 0);
		repeat (10) @(posedge clk);
		check("rx notes left", 32'h0, 32'(ev_q.size()));
		check("tx notes left", 32'h0, 32'(tx_q.size()));
		$display("transmit done");
		complete_run;
	end
	initial begin
		repeat (20000) @(posedge clk);
		failures++;
		$display("BAD watchdog expected done seen hang");
		complete_run;
	end
endmodule
`default_nettype wire
